//--- hdl/seg_driver_pkg.sv
package seg_driver_pkg;

    localparam int  SEG_COUNT       = 30;
    localparam int  FIFO_DEPTH      = 16;
    localparam int  FIFO_WIDTH      = 1;
    localparam int  BP_DIVIDE       = 256;
    localparam int  BP_DIV_W        = $clog2(BP_DIVIDE);
    localparam int  CLK_FREQ_HZ     = 50_000_000;
    localparam int  OSC_FREQ_HZ     = 25_600;
    localparam int  OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int  OSC_CNT_W       = $clog2(OSC_TICK_CYCLES + 1);
    localparam int  SYNC_W          = 6;
    localparam int  PIN_SCLK        = 0;
    localparam int  PIN_CS          = 1;
    localparam int  PIN_LOAD        = 2;
    localparam int  PIN_DIN         = 3;
    localparam int  PIN_OSC         = 4;
    localparam int  PIN_OPT         = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;

endpackage

//--- hdl/bit_fifo.sv
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

//--- hdl/serial_lcd_segment_driver.sv
`timescale 1ns/1ps
// Operation
// - shift only while chip select low
// - falling shift clock shifts data in
// - last stage out on rising clock
// - load high makes latch transparent
// - load falling edge holds latch contents
// - select toggle with clock low shifts once
// - latched one drives segment in antiphase
// - option pin high selects internal oscillator
// - internal backplane is oscillator over 256
// - external clock resets divider each cycle
// - fixed select variant treats select low
// - oscillator pin held high with option pin low gives static outputs
module serial_lcd_segment_driver
    import seg_driver_pkg::*;
#(
    parameter int SEGS     = SEG_COUNT,
    parameter bit CS_FIXED = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            ce,
    input  wire logic            shift_clk_n,
    input  wire logic            chip_select_n,
    input  wire logic            load,
    input  wire logic            data_in,
    input  wire logic            osc_clock_pin,
    input  wire logic            osc_option_pin,
    input  wire logic            hold_shift,
    output logic                 data_out_ff,
    output logic                 backplane_out_ff,
    output logic      [SEGS-1:0] segment_out_ff,
    output logic                 accept_ready_ff
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] prev_ff;
    logic [SYNC_W-1:0] pins;

    // pin order matches the PIN_ indices
    assign pins = {osc_option_pin, osc_clock_pin, data_in,
                   load, chip_select_n, shift_clk_n};

    // syncs reset to idle pin levels, so no false edge after reset
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_ff[gi] <= SYNC_RESET[gi];
                    sync2_ff[gi] <= SYNC_RESET[gi];
                    prev_ff[gi]  <= SYNC_RESET[gi];
                end else if (ce) begin
                    sync1_ff[gi] <= pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // shift events into the fifo

    logic cs_n_eff;
    logic cs_toggle;
    logic sclk_fall;
    logic sclk_rise;
    logic shift_event;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_data;
    logic pop;
    logic drain_ready;

    assign cs_n_eff  = CS_FIXED ? 1'b0 : sync2_ff[PIN_CS];
    // a select change with the clock low is one extra shift
    assign cs_toggle = !CS_FIXED && !sync2_ff[PIN_SCLK]
                     && (sync2_ff[PIN_CS] != prev_ff[PIN_CS]);
    assign sclk_fall = prev_ff[PIN_SCLK] & ~sync2_ff[PIN_SCLK];
    assign sclk_rise = ~prev_ff[PIN_SCLK] & sync2_ff[PIN_SCLK];
    assign shift_event = (sclk_fall & ~cs_n_eff) | cs_toggle;

    // shifts beyond the fifo room are dropped and flagged
    bit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .in_valid  (shift_event),
        .in_ready  (fifo_in_ready),
        .in_data   (sync2_ff[PIN_DIN]),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    assign drain_ready = ~hold_shift;
    assign pop         = ce & fifo_out_valid & drain_ready;

    // registered so the output comes from a flop; one cycle late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accept_ready_ff <= 1'b0;
        end else if (ce) begin
            accept_ready_ff <= fifo_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register, serial out and latch

    logic [SEGS-1:0] sr_ff;
    logic [SEGS-1:0] latch_ff;

    // bit 0 is stage one, driving segment one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sr_ff <= '0;
        end else if (pop) begin
            sr_ff <= {sr_ff[SEGS-2:0], fifo_out_data};
        end
    end

    // serial out moves only on a rising shift clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out_ff <= 1'b0;
        end else if (ce && sclk_rise) begin
            data_out_ff <= sr_ff[SEGS-1];
        end
    end

    // transparent while high, last value kept after the fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_ff <= '0;
        end else if (ce && sync2_ff[PIN_LOAD]) begin
            latch_ff <= sr_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // backplane generation

    logic [OSC_CNT_W-1:0] osc_cnt_ff;
    logic [BP_DIV_W-1:0]  div_ff;
    logic                 osc_tick;
    logic                 ext_rise;
    logic                 ext_fall;
    logic                 internal_mode;
    logic                 nxt_bp;

    assign internal_mode = sync2_ff[PIN_OPT];
    assign osc_tick = (osc_cnt_ff == OSC_CNT_W'(OSC_TICK_CYCLES - 1));
    assign ext_rise = ~prev_ff[PIN_OSC] & sync2_ff[PIN_OSC];
    assign ext_fall = prev_ff[PIN_OSC] & ~sync2_ff[PIN_OSC];

    // internal oscillator: one tick every OSC_TICK_CYCLES
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt_ff <= '0;
        end else if (ce) begin
            osc_cnt_ff <= (osc_tick || !internal_mode)
                          ? '0 : osc_cnt_ff + 1'b1;
        end
    end

    // divider steps only in internal mode; external rising edges restart it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else if (ce) begin
            if (!internal_mode && ext_rise) begin
                div_ff <= '0;
            end else if (internal_mode && osc_tick) begin
                div_ff <= div_ff + 1'b1;
            end
        end
    end

    // external mode follows pin edges and holds while the pin is quiet
    always_comb begin
        if (internal_mode) begin
            nxt_bp = div_ff[BP_DIV_W-1];
        end else if (ext_rise) begin
            nxt_bp = 1'b1;
        end else if (ext_fall) begin
            nxt_bp = 1'b0;
        end else begin
            nxt_bp = backplane_out_ff;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            backplane_out_ff <= 1'b0;
        end else if (ce) begin
            backplane_out_ff <= nxt_bp;
        end
    end

    // segments use nxt_bp so both outputs change on one edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            segment_out_ff <= '0;
        end else if (ce) begin
            segment_out_ff <= latch_ff ^ {SEGS{nxt_bp}};
        end
    end

endmodule

//--- verification/seg_drv_chk.sv
`timescale 1ns/1ps
module seg_drv_chk #(parameter int SEGS = 30) (
    input wire logic            clk,
    input wire logic            reset_n,
    input wire logic            ce,
    input wire logic            shift_clk_n,
    input wire logic            chip_select_n,
    input wire logic            load,
    input wire logic            osc_clock_pin,
    input wire logic            osc_option_pin,
    input wire logic            hold_shift,
    input wire logic            data_out_ff,
    input wire logic            backplane_out_ff,
    input wire logic [SEGS-1:0] segment_out_ff,
    input wire logic            accept_ready_ff
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n || !ce);
// cycles spent deselected with the latch open
logic [3:0] idle_ff;
always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) idle_ff <= 4'h0;
    else if (!(chip_select_n && load && !hold_shift)) idle_ff <= 4'h0;
    else if (idle_ff != 4'hF) idle_ff <= idle_ff + 4'h1;
a_seg_flip: assert property (
    (!load)[*7] ##0 $changed(backplane_out_ff)
    |-> segment_out_ff == ~$past(segment_out_ff)) else $error("seg flip");
a_seg_hold: assert property (
    (!load)[*7] ##0 $stable(backplane_out_ff)
    |-> $stable(segment_out_ff)) else $error("seg hold");
a_desel_keep: assert property (
    idle_ff > 4'hB && $stable(backplane_out_ff)
    |-> $stable(segment_out_ff)) else $error("desel shift");
a_ready_back: assert property (
    (!hold_shift)[*4] |-> accept_ready_ff) else $error("ready");
a_bp_ext: assert property (
    (!osc_option_pin)[*6]
    |-> backplane_out_ff == $past(osc_clock_pin, 3)) else $error("bp ext");
a_bp_rise: assert property (
    (!osc_option_pin)[*6] ##0 $rose(backplane_out_ff)
    |-> !$past(osc_clock_pin, 4)) else $error("bp rise");
a_bp_static: assert property (
    (!osc_option_pin && osc_clock_pin)[*6]
    |-> backplane_out_ff && $stable(backplane_out_ff)) else $error("static");
a_dout_rise: assert property (
    $changed(data_out_ff)
    |-> $past(shift_clk_n, 2) && !$past(shift_clk_n, 5)) else $error("dout");
endmodule

//--- verification/seg_host.sv
`timescale 1ns/1ps
// three shared control lines plus one data line
module seg_host (
    input  wire logic clk,
    output logic      shift_clk_n,
    output logic      chip_select_n,
    output logic      load,
    output logic      data_in
);
initial begin
    shift_clk_n = 1'b1;
    chip_select_n = 1'b1;
    load = 1'b0;
    data_in = 1'b0;
end
task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic put_bit(input logic b, input logic sel);
    chip_select_n = !sel;
    data_in = b;
    step(4);
    shift_clk_n = 1'b0;
    step(4);
    shift_clk_n = 1'b1;
    data_in = !b;
    step(4);
endtask
task automatic cs_toggle();
    chip_select_n = 1'b1;
    data_in = 1'b1;
    step(4);
    shift_clk_n = 1'b0;
    step(4);
    chip_select_n = 1'b0;
    step(4);
    chip_select_n = 1'b1;
    step(4);
    shift_clk_n = 1'b1;
    step(4);
endtask
task automatic set_load(input logic v);
    load = v;
    step(6);
endtask
endmodule

//--- verification/test_serial_lcd_segment_driver.sv
`timescale 1ns/1ps
module test_serial_lcd_segment_driver;
import seg_driver_pkg::*;
localparam int N = SEG_COUNT;
logic clk, reset_n, osc_clock_pin, osc_option_pin, hold_shift, look, dq;
logic shift_clk_n, chip_select_n, load, data_in, ce;
logic data_out_ff, backplane_out_ff, accept_ready_ff;
logic [N-1:0] segment_out_ff, sr, lat;
logic [N+1:0] notes[$];
logic [31:0]  rng;
int           n_fail, num_checks, room;
seg_host host_u (.clk, .shift_clk_n, .chip_select_n, .load, .data_in);
serial_lcd_segment_driver dut_u (.clk, .reset_n, .ce(ce), .shift_clk_n,
    .chip_select_n, .load, .data_in, .osc_clock_pin, .osc_option_pin,
    .hold_shift, .data_out_ff, .backplane_out_ff, .segment_out_ff,
    .accept_ready_ff);
////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
endfunction
task automatic check(input logic [N+1:0] got, input logic [N+1:0] exp);
    num_checks++;
    if (got !== exp) begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic report_and_stop();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task automatic send(input logic [N-1:0] v, input int n, input logic sel);
    for (int i = n - 1; i >= 0; i--) begin
        host_u.put_bit(v[i], sel);
        if (sel && (!hold_shift || room > 0)) begin
            sr = {sr[N-2:0], v[i]};
            room--;
        end
        if (!hold_shift) dq = sr[N-1];
    end
endtask
task automatic expect_now();
    notes.push_back({osc_option_pin ? 1'b0 : osc_clock_pin, dq, lat});
    look = 1'b1;
    host_u.step(1);
    look = 1'b0;
endtask
task automatic latch_and_expect();
    host_u.set_load(1'b1);
    host_u.set_load(1'b0);
    lat = sr;
    expect_now();
endtask
////////////////////////////////////////////////////////////////////////
always @(posedge clk)
    if (look) check({backplane_out_ff, data_out_ff,
        segment_out_ff ^ {N{backplane_out_ff}}}, notes.pop_front());
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
initial begin
    #400000;
    n_fail++;
    report_and_stop();
end
initial begin
    {ce, reset_n, look, hold_shift, dq, osc_clock_pin} = 6'h20;
    osc_option_pin = 1'b1;
    {n_fail, num_checks, sr, lat, rng} = {32'h0, 32'h0, 60'h0, 32'h61};
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    host_u.step(4);
    for (int k = 0; k < 6; k++) begin
        rng = xs(rng);
        send(rng[N-1:0], N, 1'b1);
        if (k > 1) osc_option_pin = 1'b0;
        if (k > 2) osc_clock_pin = ~osc_clock_pin;
        latch_and_expect();
        $display("word test %0d done", k);
    end
    host_u.set_load(1'b1);
    send(~sr, 5, 1'b1);
    host_u.set_load(1'b0);
    lat = sr;
    rng = xs(rng);
    send(rng[N-1:0], 9, 1'b1);
    expect_now();
    host_u.set_load(1'b1);
    send(~sr, 8, 1'b0);
    host_u.set_load(1'b0);
    lat = sr;
    expect_now();
    host_u.cs_toggle();
    sr = {sr[N-3:0], 2'b11};
    dq = sr[N-1];
    latch_and_expect();
    $display("control tests done");
    hold_shift = 1'b1;
    room = 16;
    rng = xs(rng);
    send(rng[N-1:0], 20, 1'b1);
    check((N+2)'(accept_ready_ff), (N+2)'(0));
    {ce, hold_shift} = 2'b00;
    host_u.step(20);
    check((N+2)'(accept_ready_ff), (N+2)'(0));
    ce = 1'b1;
    host_u.step(20);
    check((N+2)'(accept_ready_ff), (N+2)'(1));
    latch_and_expect();
    $display("buffer test done");
    report_and_stop();
end
endmodule
bind serial_lcd_segment_driver seg_drv_chk #(.SEGS(SEGS)) chk_u (.clk,
    .reset_n, .ce, .shift_clk_n, .chip_select_n, .load, .osc_clock_pin,
    .osc_option_pin, .hold_shift, .data_out_ff, .backplane_out_ff,
    .segment_out_ff, .accept_ready_ff);
